/* src/idr_map.svh */
/*
 * Register indices, field positions, reset values and timing counts of the input
 * diagnostic register bank.
 * Assumes a Wishbone byte address whose bits [7:2] carry the register index.
 */
// Behaviour
// - open-check enable bit n-1 arms channel n
// - manual mode: enable bit drives common-mode high
// - sticky per-channel open flags, write one clears
// - one enable bit per channel for voltage checks
// - sticky per-channel overvoltage flags, write one clears
// - sticky per-channel undervoltage flags, write one clears
// - selector fields [2:0] and [5:3], [7:6] read zero
// - selector codes map to eight diagnostic sources
`ifndef IDR_MAP_SVH
`define IDR_MAP_SVH

// register indices, byte address is four times the index
`define IDR_IDX_OPEN_EN 6'h23
`define IDR_IDX_OPEN_FLAGS 6'h24
`define IDR_IDX_VOLT_EN 6'h25
`define IDR_IDX_OVER_FLAGS 6'h26
`define IDR_IDX_UNDER_FLAGS 6'h27
`define IDR_IDX_DIAG_SEL 6'h28
`define IDR_IDX_IRQ_STATUS 6'h30
`define IDR_IDX_IRQ_MASK 6'h31
`define IDR_IDX_CONTROL 6'h32

// reset values
`define IDR_RST_OPEN_EN 8'h00
`define IDR_RST_VOLT_EN 8'h00
`define IDR_RST_DIAG_SEL 6'h00
`define IDR_RST_IRQ_MASK 3'h0
`define IDR_RST_CONTROL 1'h0

// field positions
`define IDR_SEL_CH1_LSB 0
`define IDR_SEL_CH2_LSB 3
`define IDR_SEL_BITS 3
`define IDR_CTRL_MANUAL_BIT 0
`define IDR_IRQ_OPEN_BIT 0
`define IDR_IRQ_OVER_BIT 1
`define IDR_IRQ_UNDER_BIT 2

// wishbone answer: ack is raised one cycle after the request appears
`define IDR_ACK_LATENCY 1

`endif

/* src/idr_pkg.sv */
/*
 * Types shared by the input diagnostic register bank.
 * Assumes idr_map.svh is on the include path.
 */
package idr_pkg;

	// diagnostic sources in selector code order; code 100 differs per channel
	typedef enum logic [2:0] {
		IDR_SRC_INPUT_PIN,
		IDR_SRC_TEMP_SENSOR,
		IDR_SRC_REF_2V5,
		IDR_SRC_ANALOG_REG,
		IDR_SRC_DIGITAL_REG,
		IDR_SRC_INTERFACE_SUPPLY,
		IDR_SRC_ANALOG_GROUND,
		IDR_SRC_ANALOG_SUPPLY
	} idr_src_t;

	// three detector groups: open, over, under
	typedef logic [2:0][7:0] idr_det_t;

	// state of the register bank apart from the sticky flag groups
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [7:0] open_en;
		logic [7:0] volt_en;
		logic [5:0] diag_sel;
		logic manual;
		logic [2:0] irq_mask;
		idr_det_t sync1;
		idr_det_t sync2;
		idr_det_t sync3;
		idr_det_t level;
		idr_src_t ch1_src;
		idr_src_t ch2_src;
		logic [1:0] range_10v;
	} idr_state_t;

	// state of one sticky flag group
	typedef struct packed {
		logic [7:0] flags;
	} idr_sticky_t;

endpackage

/* src/idr_sticky.sv */
/*
 * Eight sticky flags: set by hardware events, cleared by writing ones.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps
module idr_sticky (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// hardware events and software clear mask
	input wire logic [7:0] set,
	input wire logic [7:0] clr,
	// flag state
	output logic [7:0] flags
);
	import idr_pkg::*;

	idr_sticky_t st_reg;
	idr_sticky_t st_next;

	// set wins over clear; a zero in the clear mask keeps the bit
	always_comb begin
		st_next = st_reg;
		st_next.flags = (st_reg.flags & ~clr) | set;
	end

	// register the state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flags = st_reg.flags;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// an event in any cycle, even under a clear, leaves its flag set
	AST_SET_WINS: assert property ((|set) |=> ((flags & $past(set)) == $past(set)))
		else $error("sticky flag lost its set event");

	// bits not cleared keep their value
	AST_ZERO_KEEPS: assert property (1'b1 |=> ((flags & $past(flags & ~clr)) == $past(flags & ~clr)))
		else $error("sticky flag dropped without a clear");
endmodule

/* src/idr_regs.sv */
/*
 * Input diagnostic register bank: open-input, overvoltage and undervoltage
 * enables and flags, diagnostic source selectors for channels 1 and 2, and an
 * interrupt status/mask pair, all behind a classic Wishbone slave.
 * Assumes the detector inputs come from analog logic outside the clock domain
 * and the Wishbone master runs on clk.
 */
`timescale 1ns/100ps
`include "idr_map.svh"
module idr_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// detector results from the analog front end
	input wire logic [7:0] open_detected,
	input wire logic [7:0] over_detected,
	input wire logic [7:0] under_detected,
	// controls toward the analog front end
	output logic [7:0] open_check_enable,
	output logic [7:0] common_mode_high,
	output logic [7:0] voltage_check_enable,
	output idr_pkg::idr_src_t ch1_diag_source_select,
	output idr_pkg::idr_src_t ch2_diag_source_select,
	output logic [1:0] force_range_10v,
	// interrupt
	output logic irq
);
	import idr_pkg::*;

	idr_state_t st_reg;
	idr_state_t st_next;
	logic [7:0] open_flags;
	logic [7:0] over_flags;
	logic [7:0] under_flags;
	logic [7:0] irq_status;
	logic [7:0] open_set;
	logic [7:0] over_set;
	logic [7:0] under_set;
	logic [7:0] irq_set;
	logic req;
	logic wr_fire;
	logic [5:0] idx;
	logic [7:0] wdat;

	// true when the pending access addresses register index i
	function automatic logic hit(input logic [7:0] adr, input logic [5:0] i);
		hit = (adr[1:0] == 2'h0) && (adr[7:2] == i);
	endfunction

	// selector code to source; code 100 is the digital regulator on channel 1 only
	function automatic idr_src_t decode_src(input logic [2:0] code, input logic is_ch2);
		if (is_ch2 && code == 3'h4) begin
			decode_src = IDR_SRC_ANALOG_REG;
		end else begin
			decode_src = idr_src_t'(code);
		end
	endfunction

	// bus request decode; a write lands on the edge where ack is seen
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_fire = req & wb_we_i & st_reg.ack & wb_sel_i[0];
	assign idx = wb_adr_i[7:2];
	assign wdat = wb_dat_i[7:0];

	// detections count only on channels whose check is enabled
	assign open_set = st_reg.level[0] & st_reg.open_en & {8{~st_reg.manual}};
	assign over_set = st_reg.level[1] & st_reg.volt_en;
	assign under_set = st_reg.level[2] & st_reg.volt_en;

	// interrupt events fire when a flag newly goes up
	always_comb begin
		irq_set = 8'h00;
		irq_set[`IDR_IRQ_OPEN_BIT] = |(open_set & ~open_flags);
		irq_set[`IDR_IRQ_OVER_BIT] = |(over_set & ~over_flags);
		irq_set[`IDR_IRQ_UNDER_BIT] = |(under_set & ~under_flags);
	end

	// open-input flags
	idr_sticky u_open_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.set(open_set),
		.clr((wr_fire && hit(wb_adr_i, `IDR_IDX_OPEN_FLAGS)) ? wdat : 8'h00),
		.flags(open_flags)
	);

	// overvoltage flags
	idr_sticky u_over_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.set(over_set),
		.clr((wr_fire && hit(wb_adr_i, `IDR_IDX_OVER_FLAGS)) ? wdat : 8'h00),
		.flags(over_flags)
	);

	// undervoltage flags
	idr_sticky u_under_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.set(under_set),
		.clr((wr_fire && hit(wb_adr_i, `IDR_IDX_UNDER_FLAGS)) ? wdat : 8'h00),
		.flags(under_flags)
	);

	// interrupt status, one bit per event group
	idr_sticky u_irq_status (
		.clk(clk),
		.sys_rst(sys_rst),
		.set(irq_set),
		.clr((wr_fire && hit(wb_adr_i, `IDR_IDX_IRQ_STATUS)) ? wdat : 8'h00),
		.flags(irq_status)
	);

	// next state: synchronisers, bus answer and writable registers
	always_comb begin
		st_next = st_reg;
		// three-stage synchronisers; a level changes once stages two and three agree
		st_next.sync1 = {under_detected, over_detected, open_detected};
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		st_next.level = (st_reg.sync2 & st_reg.sync3) | (st_reg.level & (st_reg.sync2 | st_reg.sync3));
		// ack for one cycle, then drop it for a cycle
		st_next.ack = req & ~st_reg.ack;
		if (req && !st_reg.ack) begin
			st_next.dat = 32'h0000_0000;
			if (!wb_we_i) begin
				case (1'b1)
					hit(wb_adr_i, `IDR_IDX_OPEN_EN): st_next.dat[7:0] = st_reg.open_en;
					hit(wb_adr_i, `IDR_IDX_OPEN_FLAGS): st_next.dat[7:0] = open_flags;
					hit(wb_adr_i, `IDR_IDX_VOLT_EN): st_next.dat[7:0] = st_reg.volt_en;
					hit(wb_adr_i, `IDR_IDX_OVER_FLAGS): st_next.dat[7:0] = over_flags;
					hit(wb_adr_i, `IDR_IDX_UNDER_FLAGS): st_next.dat[7:0] = under_flags;
					hit(wb_adr_i, `IDR_IDX_DIAG_SEL): st_next.dat[5:0] = st_reg.diag_sel;
					hit(wb_adr_i, `IDR_IDX_IRQ_STATUS): st_next.dat[2:0] = irq_status[2:0];
					hit(wb_adr_i, `IDR_IDX_IRQ_MASK): st_next.dat[2:0] = st_reg.irq_mask;
					hit(wb_adr_i, `IDR_IDX_CONTROL): st_next.dat[0] = st_reg.manual;
					default: st_next.dat = 32'h0000_0000; // unmapped reads as zero
				endcase
			end
		end
		// register writes on the acknowledged edge
		if (wr_fire) begin
			if (hit(wb_adr_i, `IDR_IDX_OPEN_EN)) begin
				st_next.open_en = wdat;
			end
			if (hit(wb_adr_i, `IDR_IDX_VOLT_EN)) begin
				st_next.volt_en = wdat;
			end
			if (hit(wb_adr_i, `IDR_IDX_DIAG_SEL)) begin
				st_next.diag_sel = wdat[5:0];
			end
			if (hit(wb_adr_i, `IDR_IDX_IRQ_MASK)) begin
				st_next.irq_mask = wdat[2:0];
			end
			if (hit(wb_adr_i, `IDR_IDX_CONTROL)) begin
				st_next.manual = wdat[`IDR_CTRL_MANUAL_BIT];
			end
		end
		// decoded sources and range forcing follow the selectors a cycle later
		st_next.ch1_src = decode_src(st_reg.diag_sel[`IDR_SEL_CH1_LSB +: `IDR_SEL_BITS], 1'b0);
		st_next.ch2_src = decode_src(st_reg.diag_sel[`IDR_SEL_CH2_LSB +: `IDR_SEL_BITS], 1'b1);
		st_next.range_10v[0] = |st_reg.diag_sel[`IDR_SEL_CH1_LSB +: `IDR_SEL_BITS];
		st_next.range_10v[1] = |st_reg.diag_sel[`IDR_SEL_CH2_LSB +: `IDR_SEL_BITS];
	end

	// register the state with its reset values
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.open_en <= `IDR_RST_OPEN_EN;
			st_reg.volt_en <= `IDR_RST_VOLT_EN;
			st_reg.diag_sel <= `IDR_RST_DIAG_SEL;
			st_reg.irq_mask <= `IDR_RST_IRQ_MASK;
			st_reg.manual <= `IDR_RST_CONTROL;
			st_reg.ch1_src <= IDR_SRC_INPUT_PIN;
			st_reg.ch2_src <= IDR_SRC_INPUT_PIN;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.dat;
	assign open_check_enable = st_reg.manual ? 8'h00 : st_reg.open_en;
	assign common_mode_high = st_reg.manual ? st_reg.open_en : 8'h00;
	assign voltage_check_enable = st_reg.volt_en;
	assign ch1_diag_source_select = st_reg.ch1_src;
	assign ch2_diag_source_select = st_reg.ch2_src;
	assign force_range_10v = st_reg.range_10v;
	assign irq = |(irq_status[2:0] & st_reg.irq_mask);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// a write to the open enable reaches the detectors in automatic mode
	AST_OPEN_WRITE: assert property ((wr_fire && hit(wb_adr_i, `IDR_IDX_OPEN_EN) && !st_reg.manual)
		|=> (open_check_enable == $past(wdat)) && (common_mode_high == 8'h00))
		else $error("open check enable did not follow the write");

	// in manual mode the enable bits drive common mode instead
	AST_MANUAL_CM: assert property ((wr_fire && hit(wb_adr_i, `IDR_IDX_OPEN_EN) && st_reg.manual)
		|=> (common_mode_high == $past(wdat)) && (open_check_enable == 8'h00))
		else $error("common mode control did not follow the write");

	// an enabled open detection lands in its flag
	AST_OPEN_SET: assert property ((|open_set) |=> ((open_flags & $past(open_set)) == $past(open_set)))
		else $error("open detection not flagged");

	// an armed input seen on three edges shows its flag on the third edge after the last
	AST_OPEN_LATENCY: assert property ((open_detected[0] && !st_reg.manual && st_reg.open_en[0])
		[*3] |=> ##2 open_flags[0])
		else $error("open flag late for channel 1");

	// voltage enable write lands a cycle later
	AST_VOLT_WRITE: assert property ((wr_fire && hit(wb_adr_i, `IDR_IDX_VOLT_EN))
		|=> voltage_check_enable == $past(wdat))
		else $error("voltage enable did not follow the write");

	// overvoltage detections on enabled channels are latched
	AST_OVER_SET: assert property ((|over_set) |=> ((over_flags & $past(over_set)) == $past(over_set)))
		else $error("overvoltage not flagged");

	// disabled channels never gain an undervoltage flag
	AST_UNDER_GATE: assert property ((!wr_fire && st_reg.volt_en == 8'h00)
		|=> ((under_flags & ~$past(under_flags)) == 8'h00))
		else $error("undervoltage flagged on a disabled channel");

	// selector read returns reserved bits as zero
	AST_SEL_RESERVED: assert property ((req && !st_reg.ack && !wb_we_i && hit(wb_adr_i, `IDR_IDX_DIAG_SEL))
		|=> wb_ack_o && (wb_dat_o[31:6] == 26'h0))
		else $error("selector read shows reserved bits");

	// channel 2 code 100 selects the analog regulator two edges after the write
	AST_CH2_CODE4: assert property ((wr_fire && hit(wb_adr_i, `IDR_IDX_DIAG_SEL) && wdat[5:3] == 3'h4)
		|=> ##1 ch2_diag_source_select == IDR_SRC_ANALOG_REG)
		else $error("channel 2 code 100 decoded wrongly");

	// channel 1 code 100 selects the digital regulator
	AST_CH1_CODE4: assert property ((wr_fire && hit(wb_adr_i, `IDR_IDX_DIAG_SEL) && wdat[2:0] == 3'h4)
		|=> ##1 (ch1_diag_source_select == IDR_SRC_DIGITAL_REG) && force_range_10v[0])
		else $error("channel 1 code 100 decoded wrongly");

	// ack is a single-cycle pulse
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule

/* tb/test_idr_regs.sv */
/*
 * Self-checking bench for the input diagnostic register bank: reset values,
 * enables, sticky flags with interrupt, selectors and unmapped addresses.
 * Assumes idr_pkg is compiled first and idr_map.svh is on the include path.
 */
`timescale 1ns/100ps
module test_idr_regs;
	import idr_pkg::*;

	logic clk;
	logic sys_rst;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [2:0][7:0] det;
	logic [7:0] open_check_enable;
	logic [7:0] common_mode_high;
	logic [7:0] voltage_check_enable;
	idr_src_t ch1_diag_source_select;
	idr_src_t ch2_diag_source_select;
	logic [1:0] force_range_10v;
	logic irq;
	int bad_count;
	int compares;
	logic [31:0] q;

	idr_regs dut_u (
		.clk(clk),
		.sys_rst(sys_rst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.open_detected(det[0]),
		.over_detected(det[1]),
		.under_detected(det[2]),
		.open_check_enable(open_check_enable),
		.common_mode_high(common_mode_high),
		.voltage_check_enable(voltage_check_enable),
		.ch1_diag_source_select(ch1_diag_source_select),
		.ch2_diag_source_select(ch2_diag_source_select),
		.force_range_10v(force_range_10v),
		.irq(irq)
	);

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// verdict and end of run
	task complete_run;
		if (bad_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one comparison, mismatch reported at once
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// classic single wishbone cycle, held until ack is sampled high
	task wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] rq);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			complete_run();
		end
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] dummy;
		wb_xfer(1'b1, a, d, 4'hF, dummy);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] rq);
		wb_xfer(1'b0, a, 8'h00, 4'hF, rq);
	endtask

	// every register reads zero after reset, outputs idle, disabled detections set nothing
	task chk_reset;
		logic [7:0] adrs [9];
		adrs = '{8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hC0, 8'hC4, 8'hC8};
		det <= '1;
		repeat (3) @(posedge clk);
		det <= '0;
		repeat (6) @(posedge clk);
		foreach (adrs[i]) begin
			rd(adrs[i], q);
			check(q, 32'h00000000);
		end
		check({29'h0, ch1_diag_source_select}, 32'h00000000);
		check({24'h0, open_check_enable | voltage_check_enable}, 32'h00000000);
	endtask

	// enables read back and reach the front end, manual mode redirects the open enables
	task chk_enables;
		wr(8'h8C, 8'hA5);
		rd(8'h8C, q);
		check(q, 32'h000000A5);
		check({24'h0, open_check_enable}, 32'h000000A5);
		check({24'h0, common_mode_high}, 32'h00000000);
		wr(8'hC8, 8'h01);
		@(posedge clk);
		check({24'h0, common_mode_high}, 32'h000000A5);
		check({24'h0, open_check_enable}, 32'h00000000);
		wr(8'hC8, 8'h00);
		wr(8'h94, 8'h5A);
		rd(8'h94, q);
		check(q, 32'h0000005A);
		check({24'h0, voltage_check_enable}, 32'h0000005A);
		wr(8'h8C, 8'hFF);
		wr(8'h94, 8'hFF);
	endtask

	// detection sets sticky flags and interrupt; ones clear, zeros keep
	task chk_flags(input int g);
		logic [7:0] a;
		logic [7:0] b;
		a = (g == 0) ? 8'h90 : 8'h94 + 8'(4 * g);
		b = 8'h01 << g;
		det[g] <= 8'h81;
		repeat (3) @(posedge clk);
		det[g] <= 8'h00;
		repeat (6) @(posedge clk);
		rd(a, q);
		check(q, 32'h00000081);
		rd(8'hC0, q);
		check(q, {24'h0, b});
		check({31'h0, irq}, 32'h00000000);
		wr(8'hC4, b);
		check({31'h0, irq}, 32'h00000001);
		wr(a, 8'h00);
		rd(a, q);
		check(q, 32'h00000081);
		wr(a, 8'h01);
		rd(a, q);
		check(q, 32'h00000080);
		wr(a, 8'h80);
		rd(a, q);
		check(q, 32'h00000000);
		det[g] <= 8'h01;
		repeat (6) @(posedge clk);
		wr(a, 8'h01);
		rd(a, q);
		check(q, 32'h00000001);
		det[g] <= 8'h00;
		repeat (6) @(posedge clk);
		wr(a, 8'h01);
		rd(a, q);
		check(q, 32'h00000000);
		wr(8'hC0, b);
		@(posedge clk);
		check({31'h0, irq}, 32'h00000000);
		wr(8'hC4, 8'h00);
	endtask

	// every selector code on both channels, reserved bits read zero
	task chk_select;
		logic [2:0] c1;
		logic [2:0] c2;
		logic [2:0] e2;
		for (int i = 0; i < 8; i++) begin
			c1 = 3'(i);
			c2 = 3'h7 - c1;
			e2 = (c2 == 3'h4) ? 3'h3 : c2;
			wr(8'hA0, {2'b11, c2, c1});
			rd(8'hA0, q);
			check(q, {26'h0, c2, c1});
			check({29'h0, ch1_diag_source_select}, {29'h0, c1});
			check({29'h0, ch2_diag_source_select}, {29'h0, e2});
			check({30'h0, force_range_10v}, {30'h0, c2 != 3'h0, c1 != 3'h0});
		end
	endtask

	// unmapped and misaligned places read zero, a misaligned write stores nothing, nor does a write without lane 0
	task chk_unmapped;
		rd(8'h00, q);
		check(q, 32'h00000000);
		wr(8'h8D, 8'h00);
		rd(8'h8D, q);
		check(q, 32'h00000000);
		wb_xfer(1'b1, 8'h8C, 8'h00, 4'hE, q);
		rd(8'h8C, q);
		check(q, 32'h000000FF);
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	// main sequence
	initial begin
		bad_count = 0;
		compares = 0;
		sys_rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		det = '0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk_reset();
		chk_enables();
		for (int g = 0; g < 3; g++) begin
			chk_flags(g);
		end
		chk_select();
		chk_unmapped();
		complete_run();
	end
endmodule
